// ### src/pss_regs.svh
// Constants of the plotter step sequencer: offsets, fields, resets, times
// What this block does
// - Line-end marker fires gate window immediately
// - No plotter commands during line-end gate
// - Line-end timer-start starts no delay timer
// - Gate end fires reset window, clears latches
// - Line-end answers host despite running delay
// - Meter enable off stalls; resumes when on
// - Offline holds accept response inactive
// - Decode record, settle, then gate window
// - Gate drives command, starts motion/pen delay
// - Gate window: idle response off, accept on
// - Full sequence per record; line-end shortened
// - Settling starts only after delays expire
// - Six command pulses in three axis groups
// - Per-direction 1.5 ms step lockout one-shot
// - Three-stage one-hot phase counter per axis
// - Step clock moves counter one position
// - Cyclic phase order, reversed for opposite
// - Manual single step or 120 steps/s
// - Carriage axis as drum axis, plus limit stops
// - Pen flip-flop set/cleared, drives solenoid
// - Manual pen raise and lower control
// - Pen delay on digit 0/9, else motion
// - Cycle needs an active encoded bit line
// - Carriage limit blocks that direction only
`ifndef PSS_REGS_SVH
`define PSS_REGS_SVH

// Register byte offsets
`define PSS_CTRL_OFS 8'h00
`define PSS_MANUAL_OFS 8'h04
`define PSS_STATUS_OFS 8'h08

// Control register fields
`define PSS_CTRL_METER 0
`define PSS_CTRL_OFFLINE 1
`define PSS_CTRL_MODEL2 2
`define PSS_CTRL_RUN_LSB 3
`define PSS_CTRL_RESET 32'h0000_0000

// Manual register fields: one-shot press bits
`define PSS_MAN_LSB 0

// Times in nanoseconds, run rate in hertz
`define PSS_SETTLE_NS 100000
`define PSS_GATE_NS 50000
`define PSS_RESET_NS 60000
`define PSS_MOTION_NS 3400000
`define PSS_MOTION2_NS 5000000
`define PSS_PEN_NS 100000000
`define PSS_LOCKOUT_NS 1500000
`define PSS_RUN_HZ 120

`endif

// ### src/pss_pkg.sv
// Types and cycle helpers of the plotter step sequencer
package pss_pkg;

   // Sequencer states, one-hot
   typedef enum logic [4:0] {
      ST_IDLE = 5'b00001,
      ST_SETTLE = 5'b00010,
      ST_GATE = 5'b00100,
      ST_RESET = 5'b01000,
      ST_STALL = 5'b10000
   } pss_state_t;

   // Host character record: zero, one, two, four, eight lines
   typedef struct packed {
      logic line_end_marker;
      logic [4:0] bits;
   } pss_host_t;

   // Six plotter commands in three axis groups
   typedef struct packed {
      logic pen_down;
      logic pen_up;
      logic carr_right;
      logic carr_left;
      logic drum_down;
      logic drum_up;
   } pss_cmd_t;

   // Least time in cycles, rounded up, never below one
   function automatic int unsigned pss_cyc_up(input longint unsigned ns,
                                              input longint unsigned hz);
      longint unsigned c;
      c = (ns * hz + 64'd999_999_999) / 64'd1_000_000_000;
      if (c == 64'd0)
         c = 64'd1;
      return c[31:0];
   endfunction

endpackage

// ### src/pss_top.sv
// Plotter step sequencer: host handshake, delay timers, step and pen logic
`timescale 1ns/1ns
`include "pss_regs.svh"

module pss_top
   import pss_pkg::*;
#(
   parameter longint unsigned CLK_HZ = 250_000_000,
   parameter int unsigned SETTLE_CYC = pss_cyc_up(`PSS_SETTLE_NS, CLK_HZ),
   parameter int unsigned GATE_CYC = pss_cyc_up(`PSS_GATE_NS, CLK_HZ),
   parameter int unsigned RESET_CYC = pss_cyc_up(`PSS_RESET_NS, CLK_HZ),
   parameter int unsigned MOTION_CYC = pss_cyc_up(`PSS_MOTION_NS, CLK_HZ),
   parameter int unsigned MOTION2_CYC = pss_cyc_up(`PSS_MOTION2_NS, CLK_HZ),
   parameter int unsigned PEN_CYC = pss_cyc_up(`PSS_PEN_NS, CLK_HZ),
   parameter int unsigned LOCKOUT_CYC = pss_cyc_up(`PSS_LOCKOUT_NS, CLK_HZ),
   parameter int unsigned RUN_CYC = int'(CLK_HZ / `PSS_RUN_HZ)
)
(
   input wire logic mclk_i,
   input wire logic resetn_i,
   input wire logic [7:0] addr_i,
   input wire logic [31:0] wr_data_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [31:0] rd_data_o,
   input wire pss_host_t host_i,
   input wire logic carr_left_limit_i,
   input wire logic carr_right_limit_i,
   output logic accept_response_o,
   output logic idle_response_o,
   output logic quench_o,
   output pss_cmd_t cmd_o,
   output logic [2:0] drum_phase_o,
   output logic [2:0] carr_phase_o,
   output logic pen_lift_o
);

   // Decode a character record into one plotter command
   function automatic pss_cmd_t decode(input logic [4:0] b);
      pss_cmd_t c;
      logic [3:0] d;
      c = '0;
      d = b[0] ? 4'h0 : {b[4], b[3], b[2], b[1]};
      case (d)
         4'h0: c.pen_down = 1'b1;
         4'h1: c.drum_up = 1'b1;
         4'h2: c.drum_down = 1'b1;
         4'h3: c.carr_left = 1'b1;
         4'h4: c.carr_right = 1'b1;
         4'h5: {c.drum_up, c.carr_left} = 2'b11;
         4'h6: {c.drum_up, c.carr_right} = 2'b11;
         4'h7: {c.drum_down, c.carr_left} = 2'b11;
         4'h8: {c.drum_down, c.carr_right} = 2'b11;
         4'h9: c.pen_up = 1'b1;
         default: c = '0;
      endcase
      return c;
   endfunction

   // Pen digit test: zero or nine
   function automatic logic is_pen_digit(input logic [4:0] b);
      return b[0] || (b[4:1] == 4'h9);
   endfunction

   // Rotate a one-hot phase; forward 1-2-3, reverse 3-2-1
   function automatic logic [2:0] rotate(input logic [2:0] ph, input logic fwd);
      return fwd ? {ph[1:0], ph[2]} : {ph[0], ph[2:1]};
   endfunction

   // Input synchronisers for host pins and limits
   logic [7:0] sync1_reg;
   logic [7:0] sync2_reg;
   pss_host_t host_s;
   logic left_lim_s;
   logic right_lim_s;

   always_ff @(posedge mclk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         sync1_reg <= 8'h00;
         sync2_reg <= 8'h00;
      end
      else
      begin
         sync1_reg <= {carr_right_limit_i, carr_left_limit_i, host_i};
         sync2_reg <= sync1_reg;
      end
   end

   assign host_s = sync2_reg[5:0];
   assign left_lim_s = sync2_reg[6];
   assign right_lim_s = sync2_reg[7];

   // Software registers
   logic [31:0] ctrl_reg;
   logic [5:0] press_reg;
   logic meter_en;
   logic offline;
   logic model2;
   logic [3:0] run_dirs;

   assign meter_en = ctrl_reg[`PSS_CTRL_METER];
   assign offline = ctrl_reg[`PSS_CTRL_OFFLINE];
   assign model2 = ctrl_reg[`PSS_CTRL_MODEL2];
   assign run_dirs = ctrl_reg[`PSS_CTRL_RUN_LSB +: 4];

   // Control register write
   always_ff @(posedge mclk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         ctrl_reg <= `PSS_CTRL_RESET;
      else if (wr_i && addr_i == `PSS_CTRL_OFS)
         ctrl_reg <= {25'h0, wr_data_i[6:0]};
   end

   // Manual press bits, one cycle pulses
   always_ff @(posedge mclk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         press_reg <= 6'h00;
      else if (wr_i && addr_i == `PSS_MANUAL_OFS)
         press_reg <= wr_data_i[`PSS_MAN_LSB +: 6];
      else
         press_reg <= 6'h00;
   end

   // Sequencer state and window counter
   pss_state_t state_reg;
   pss_state_t state_next;
   logic [31:0] win_reg;
   logic [31:0] motion_reg;
   logic [31:0] pen_reg;
   logic eol_reg;
   pss_cmd_t dec_reg;
   logic pen_dig_reg;
   logic timers_busy;
   logic win_done;
   logic eligible;

   assign timers_busy = (motion_reg != 32'h0) || (pen_reg != 32'h0);
   assign win_done = (win_reg == 32'h1);
   assign eligible = (host_s.bits != 5'h00) && !offline;

   // Next state
   always_comb
   begin
      state_next = state_reg;
      case (state_reg)
         ST_IDLE:
         begin
            if (host_s.line_end_marker && !offline)
               state_next = meter_en ? ST_GATE : ST_STALL;
            else if (eligible && !timers_busy)
               state_next = meter_en ? ST_SETTLE : ST_STALL;
         end
         ST_STALL:
         begin
            if (meter_en)
               state_next = eol_reg ? ST_GATE : ST_SETTLE;
         end
         ST_SETTLE:
         begin
            if (win_done)
               state_next = ST_GATE;
         end
         ST_GATE:
         begin
            if (win_done)
               state_next = ST_RESET;
         end
         ST_RESET:
         begin
            if (win_done)
               state_next = ST_IDLE;
         end
         default: state_next = ST_IDLE;
      endcase
   end

   // State register
   always_ff @(posedge mclk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         state_reg <= ST_IDLE;
      else
         state_reg <= state_next;
   end

   // Window counter loads on each state entry
   always_ff @(posedge mclk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         win_reg <= 32'h0;
      else if (state_next != state_reg)
      begin
         case (state_next)
            ST_SETTLE: win_reg <= SETTLE_CYC;
            ST_GATE: win_reg <= GATE_CYC;
            ST_RESET: win_reg <= RESET_CYC;
            default: win_reg <= 32'h0;
         endcase
      end
      else if (win_reg != 32'h0)
         win_reg <= win_reg - 32'h1;
   end

   // Record latch: taken on cycle start, cleared by reset window
   always_ff @(posedge mclk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         eol_reg <= 1'b0;
         dec_reg <= '0;
         pen_dig_reg <= 1'b0;
      end
      else if (state_reg == ST_IDLE && state_next != ST_IDLE)
      begin
         eol_reg <= host_s.line_end_marker;
         dec_reg <= host_s.line_end_marker ? '0 : decode(host_s.bits);
         pen_dig_reg <= is_pen_digit(host_s.bits);
      end
      else if (state_reg == ST_RESET)
      begin
         eol_reg <= 1'b0;
         dec_reg <= '0;
         pen_dig_reg <= 1'b0;
      end
   end

   // Timer-start pulse on gate entry
   logic timer_start;
   assign timer_start = (state_next == ST_GATE) && (state_reg != ST_GATE);

   // Motion and pen delay timers
   always_ff @(posedge mclk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         motion_reg <= 32'h0;
         pen_reg <= 32'h0;
      end
      else
      begin
         if (timer_start && !eol_reg && !host_s.line_end_marker && !pen_dig_reg
             && state_reg != ST_IDLE)
            motion_reg <= model2 ? MOTION2_CYC : MOTION_CYC;
         else if (motion_reg != 32'h0)
            motion_reg <= motion_reg - 32'h1;
         if (timer_start && !eol_reg && pen_dig_reg && state_reg != ST_IDLE)
            pen_reg <= PEN_CYC;
         else if (pen_reg != 32'h0)
            pen_reg <= pen_reg - 32'h1;
      end
   end

   // Host responses and plotter command outputs
   always_ff @(posedge mclk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         accept_response_o <= 1'b0;
         idle_response_o <= 1'b1;
         quench_o <= 1'b0;
         cmd_o <= '0;
      end
      else
      begin
         accept_response_o <= (state_next == ST_GATE) && !offline;
         idle_response_o <= state_next != ST_GATE;
         quench_o <= state_next == ST_RESET;
         cmd_o <= (state_next == ST_GATE) ? dec_reg : '0;
      end
   end

   // Command pulse at gate start feeds the step and pen logic
   pss_cmd_t cmd_pulse;
   assign cmd_pulse = (state_reg == ST_SETTLE && state_next == ST_GATE) ? dec_reg : '0;

   // Continuous-run tick at 120 steps per second
   logic [31:0] run_reg;
   logic run_tick;

   always_ff @(posedge mclk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         run_reg <= 32'h0;
      else if (run_dirs == 4'h0 || run_reg == 32'h0)
         run_reg <= RUN_CYC - 32'h1;
      else
         run_reg <= run_reg - 32'h1;
   end

   assign run_tick = (run_dirs != 4'h0) && (run_reg == 32'h0);

   // Step requests: drum up, drum down, carriage left, carriage right
   logic [3:0] step_req;
   assign step_req = {cmd_pulse.carr_right, cmd_pulse.carr_left,
                      cmd_pulse.drum_down, cmd_pulse.drum_up}
                     | press_reg[3:0] | (run_dirs & {4{run_tick}});

   // Per-direction lockout one-shots
   logic [31:0] lock_reg [4];
   logic [3:0] step_clk;

   always_comb
   begin
      for (int i = 0; i < 4; i++)
         step_clk[i] = step_req[i] && (lock_reg[i] == 32'h0);
      step_clk[2] = step_clk[2] && !left_lim_s;
      step_clk[3] = step_clk[3] && !right_lim_s;
   end

   always_ff @(posedge mclk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         for (int i = 0; i < 4; i++)
            lock_reg[i] <= 32'h0;
      end
      else
      begin
         for (int i = 0; i < 4; i++)
         begin
            if (step_req[i] && lock_reg[i] == 32'h0)
               lock_reg[i] <= LOCKOUT_CYC;
            else if (lock_reg[i] != 32'h0)
               lock_reg[i] <= lock_reg[i] - 32'h1;
         end
      end
   end

   // Drum and carriage phase counters, one-hot
   always_ff @(posedge mclk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         drum_phase_o <= 3'b001;
         carr_phase_o <= 3'b001;
      end
      else
      begin
         if (step_clk[0] != step_clk[1])
            drum_phase_o <= rotate(drum_phase_o, step_clk[0]);
         if (step_clk[2] != step_clk[3])
            carr_phase_o <= rotate(carr_phase_o, step_clk[2]);
      end
   end

   // Pen flip-flop: up sets, down clears
   always_ff @(posedge mclk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         pen_lift_o <= 1'b0;
      else if (cmd_pulse.pen_up || press_reg[4])
         pen_lift_o <= 1'b1;
      else if (cmd_pulse.pen_down || press_reg[5])
         pen_lift_o <= 1'b0;
   end

   // Status word
   logic [31:0] status_word;
   assign status_word = {15'h0, pen_lift_o, carr_phase_o, drum_phase_o,
                         left_lim_s, right_lim_s, (pen_reg != 32'h0),
                         (motion_reg != 32'h0), eol_reg, state_reg};

   // Read data, one cycle after the strobe; zero otherwise
   always_ff @(posedge mclk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         rd_data_o <= 32'h0;
      else if (rd_i)
      begin
         case (addr_i)
            `PSS_CTRL_OFS: rd_data_o <= ctrl_reg;
            `PSS_STATUS_OFS: rd_data_o <= status_word;
            default: rd_data_o <= 32'h0;
         endcase
      end
      else
         rd_data_o <= 32'h0;
   end

endmodule // pss_top

// ### tb/pss_top_asserts.sv
// Checker on the top-level ports of the plotter step sequencer
`timescale 1ns/1ns
module pss_top_asserts
   import pss_pkg::*;
#(
   parameter int unsigned GATE_CYC = 4,
   parameter int unsigned RESET_CYC = 4
)
(
   input wire logic mclk_i,
   input wire logic resetn_i,
   input wire logic accept_response_o,
   input wire logic idle_response_o,
   input wire logic quench_o,
   input wire pss_cmd_t cmd_o,
   input wire logic [2:0] drum_phase_o,
   input wire logic [2:0] carr_phase_o
);
   logic [31:0] gate_cnt_reg;
   logic [31:0] qch_cnt_reg;

   // Run lengths of gate and reset windows
   always_ff @(posedge mclk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         gate_cnt_reg <= '0;
         qch_cnt_reg <= '0;
      end
      else
      begin
         gate_cnt_reg <= accept_response_o ? gate_cnt_reg + 32'h1 : '0;
         qch_cnt_reg <= quench_o ? qch_cnt_reg + 32'h1 : '0;
      end
   end

   default clocking dc @(posedge mclk_i);
   endclocking
   default disable iff (!resetn_i);

   AST_RESP_INVERSE: assert property (accept_response_o != idle_response_o)
      else $error("idle response not inverse of accept");
   AST_GATE_LENGTH: assert property ($fell(accept_response_o) |-> gate_cnt_reg == GATE_CYC)
      else $error("gate window length wrong");
   AST_RESET_AFTER_GATE: assert property ($fell(accept_response_o) |-> quench_o)
      else $error("reset window not fired at gate end");
   AST_RESET_LENGTH: assert property ($fell(quench_o) |-> qch_cnt_reg == RESET_CYC)
      else $error("reset window length wrong");
   AST_CMD_IN_GATE: assert property (cmd_o != '0 |-> accept_response_o && !quench_o)
      else $error("command outside gate window");
   AST_CMD_STEADY: assert property (accept_response_o && $past(accept_response_o) |-> $stable(cmd_o))
      else $error("command changed inside gate");
   AST_DRUM_ONEHOT: assert property ($onehot(drum_phase_o))
      else $error("drum phase not one-hot");
   AST_CARR_ONEHOT: assert property ($onehot(carr_phase_o))
      else $error("carriage phase not one-hot");
   AST_DRUM_STEP: assert property (!$stable(drum_phase_o) |->
      drum_phase_o == {$past(drum_phase_o[1:0]), $past(drum_phase_o[2])} ||
      drum_phase_o == {$past(drum_phase_o[0]), $past(drum_phase_o[2:1])})
      else $error("drum phase jumped");
   AST_CARR_STEP: assert property (!$stable(carr_phase_o) |->
      carr_phase_o == {$past(carr_phase_o[1:0]), $past(carr_phase_o[2])} ||
      carr_phase_o == {$past(carr_phase_o[0]), $past(carr_phase_o[2:1])})
      else $error("carriage phase jumped");
endmodule // pss_top_asserts

bind pss_top pss_top_asserts #(.GATE_CYC(GATE_CYC), .RESET_CYC(RESET_CYC)) asserts_u (
   .mclk_i(mclk_i), .resetn_i(resetn_i), .accept_response_o(accept_response_o),
   .idle_response_o(idle_response_o), .quench_o(quench_o), .cmd_o(cmd_o),
   .drum_phase_o(drum_phase_o), .carr_phase_o(carr_phase_o));

// ### tb/pss_host_model.sv
// Host output register model: latches a record, cleared by quench
`timescale 1ns/1ns
module pss_host_model
   import pss_pkg::*;
(
   input wire logic mclk_i,
   input wire logic resetn_i,
   input wire logic fire_i,
   input wire pss_host_t rec_i,
   input wire logic quench_i,
   output pss_host_t host_o
);
   // Latch held until the reset window clears it
   always_ff @(posedge mclk_i or negedge resetn_i)
   begin
      if (!resetn_i)
         host_o <= '0;
      else if (quench_i)
         host_o <= '0;
      else if (fire_i)
         host_o <= rec_i;
   end
endmodule // pss_host_model

// ### tb/pss_top_tb_top.sv
// Testbench of the plotter step sequencer
`timescale 1ns/1ns
`include "pss_regs.svh"
module pss_top_tb_top;
   import pss_pkg::*;
   localparam int SET = 8;
   localparam int GATE = 6;
   localparam int RSTW = 5;
   logic mclk_i = 1'b0;
   logic resetn_i = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdat = 32'h0;
   logic wr_s = 1'b0;
   logic rd_s = 1'b0;
   logic [31:0] rdat;
   logic fire = 1'b0;
   pss_host_t rec = '0;
   pss_host_t host;
   logic lim_r = 1'b0;
   logic lim_l = 1'b0;
   logic idl;
   logic acc;
   logic qch;
   pss_cmd_t cmd;
   logic [2:0] dph;
   logic [2:0] cph;
   logic pen;
   logic [2:0] ed = 3'h1;
   logic [2:0] ec = 3'h1;
   int mismatches = 0;
   int check_count = 0;
   int cyc = 0;
   int lat;
   logic [31:0] v;

   // Clock and cycle ceiling
   always #2 mclk_i = ~mclk_i;
   always @(posedge mclk_i)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         mismatches++;
         tally_and_finish();
      end
   end

   pss_top #(.SETTLE_CYC(SET), .GATE_CYC(GATE), .RESET_CYC(RSTW), .MOTION_CYC(30), .MOTION2_CYC(34),
      .PEN_CYC(60), .LOCKOUT_CYC(8), .RUN_CYC(10)) dut_u (
      .mclk_i(mclk_i), .resetn_i(resetn_i), .addr_i(addr), .wr_data_i(wdat), .wr_i(wr_s),
      .rd_i(rd_s), .rd_data_o(rdat), .host_i(host), .carr_left_limit_i(lim_l),
      .carr_right_limit_i(lim_r), .accept_response_o(acc), .idle_response_o(idl),
      .quench_o(qch), .cmd_o(cmd), .drum_phase_o(dph), .carr_phase_o(cph), .pen_lift_o(pen));
   pss_host_model host_u (.mclk_i(mclk_i), .resetn_i(resetn_i), .fire_i(fire), .rec_i(rec),
      .quench_i(qch), .host_o(host));

   function automatic logic [2:0] rot(input logic [2:0] p, input logic f);
      return f ? {p[1:0], p[2]} : {p[0], p[2:1]};
   endfunction
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      check_count++;
      if (g !== e)
      begin
         mismatches++;
         $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk_i);
      addr <= a;
      wdat <= d;
      wr_s <= 1'b1;
      @(posedge mclk_i);
      wr_s <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      @(posedge mclk_i);
      addr <= a;
      rd_s <= 1'b1;
      @(posedge mclk_i);
      rd_s <= 1'b0;
      @(negedge mclk_i);
      d = rdat;
   endtask
   // Host latches a record or line-end marker
   task automatic send(input logic le, input logic [4:0] b);
      @(posedge mclk_i);
      fire <= 1'b1;
      rec <= {le, b};
      @(posedge mclk_i);
      fire <= 1'b0;
   endtask
   task automatic wait_acc();
      lat = 0;
      while (acc !== 1'b1 && lat < 400)
      begin
         @(negedge mclk_i);
         lat++;
      end
   endtask
   task automatic wait_done();
      int n;
      n = 0;
      while (qch !== 1'b1 && n < 60)
      begin
         @(negedge mclk_i);
         n++;
      end
      while (qch !== 1'b0 && n < 60)
      begin
         @(negedge mclk_i);
         n++;
      end
      chk(n < 60, 1);
   endtask
   task automatic op(input logic [4:0] b, input logic [5:0] e);
      send(1'b0, b);
      wait_acc();
      chk(cmd, e);
      wait_done();
   endtask

   task automatic reset_check();
      rd(`PSS_CTRL_OFS, v);
      chk(v, 32'h0);
      rd(`PSS_STATUS_OFS, v);
      chk(v, 32'h0000_2401);
      rd(8'h0C, v);
      chk(v, 32'h0);
   endtask
   task automatic stall_test();
      send(1'b0, 5'h04);
      repeat (40) @(negedge mclk_i);
      chk(acc, 1'b0);
      rd(`PSS_STATUS_OFS, v);
      chk(v[4:0], 5'h10);
      wr(`PSS_CTRL_OFS, 32'h1);
      wait_acc();
      chk(cmd, 6'h02);
      wait_done();
      ed = rot(ed, 1'b0);
      chk(dph, ed);
   endtask
   task automatic offline_test();
      wr(`PSS_CTRL_OFS, 32'h3);
      send(1'b0, 5'h06);
      repeat (40) @(negedge mclk_i);
      chk(acc, 1'b0);
      wr(`PSS_CTRL_OFS, 32'h1);
      wait_acc();
      chk(cmd, 6'h04);
      wait_done();
      ec = rot(ec, 1'b1);
      chk(cph, ec);
   endtask
   task automatic run_digits();
      logic [5:0] tab [10];
      tab = '{6'h20, 6'h01, 6'h02, 6'h04, 6'h08, 6'h05, 6'h09, 6'h06, 6'h0A, 6'h10};
      for (int d = 0; d < 10; d++)
      begin
         op(d == 0 ? 5'h01 : {d[3:0], 1'b0}, tab[d]);
         if (tab[d][1:0] != 2'b00)
            ed = rot(ed, tab[d][0]);
         if (tab[d][3:2] != 2'b00)
            ec = rot(ec, tab[d][2]);
         chk({pen, cph, dph}, {tab[d] == 6'h10, ec, ed});
      end
      send(1'b0, 5'h01);
      wait_acc();
      chk(lat > 49, 1);
      wait_done();
      chk(pen, 1'b0);
   endtask
   task automatic eol_test();
      repeat (80) @(negedge mclk_i);
      send(1'b1, 5'h00);
      wait_acc();
      chk(lat <= 8, 1);
      chk(cmd, 6'h00);
      chk(idl, 1'b0);
      wait_done();
      chk(idl, 1'b1);
      op(5'h02, 6'h01);
      chk(lat <= SET + 8, 1);
      ed = rot(ed, 1'b1);
      send(1'b1, 5'h00);
      wait_acc();
      chk(lat <= 8, 1);
      wait_done();
      chk({cph, dph}, {ec, ed});
   endtask
   task automatic limit_test();
      @(posedge mclk_i);
      lim_r <= 1'b1;
      repeat (80) @(negedge mclk_i);
      op(5'h08, 6'h08);
      chk(cph, ec);
      op(5'h06, 6'h04);
      ec = rot(ec, 1'b1);
      chk(cph, ec);
      @(posedge mclk_i);
      lim_r <= 1'b0;
      lim_l <= 1'b1;
      op(5'h06, 6'h04);
      chk(cph, ec);
      op(5'h08, 6'h08);
      ec = rot(ec, 1'b0);
      chk(cph, ec);
      @(posedge mclk_i);
      lim_l <= 1'b0;
   endtask
   task automatic manual_test();
      wr(`PSS_MANUAL_OFS, 32'h1);
      wr(`PSS_MANUAL_OFS, 32'h1);
      ed = rot(ed, 1'b1);
      repeat (6) @(negedge mclk_i);
      chk(dph, ed);
      wr(`PSS_MANUAL_OFS, 32'h2);
      ed = rot(ed, 1'b0);
      repeat (6) @(negedge mclk_i);
      chk(dph, ed);
      wr(`PSS_MANUAL_OFS, 32'h10);
      repeat (4) @(negedge mclk_i);
      chk(pen, 1'b1);
      wr(`PSS_MANUAL_OFS, 32'h20);
      repeat (4) @(negedge mclk_i);
      chk(pen, 1'b0);
   endtask
   // Empty record, continuous run, long motion delay
   task automatic run_model_test();
      send(1'b0, 5'h00);
      repeat (30) @(negedge mclk_i);
      chk(acc, 1'b0);
      wr(`PSS_CTRL_OFS, 32'h9);
      repeat (83) @(posedge mclk_i);
      wr(`PSS_CTRL_OFS, 32'h5);
      repeat (8) ed = rot(ed, 1'b1);
      repeat (20) @(negedge mclk_i);
      chk(dph, ed);
      op(5'h02, 6'h01);
      ed = rot(ed, 1'b1);
      op(5'h04, 6'h02);
      chk(lat > 28, 1);
      ed = rot(ed, 1'b0);
      chk(dph, ed);
   endtask

   task automatic tally_and_finish();
      $display("checks=%0d mismatches=%0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   // Main sequence
   initial
   begin
      repeat (6) @(posedge mclk_i);
      resetn_i <= 1'b1;
      reset_check();
      stall_test();
      offline_test();
      run_digits();
      eol_test();
      limit_test();
      manual_test();
      run_model_test();
      tally_and_finish();
   end
endmodule // pss_top_tb_top
